// ==== verilog/cc_module.v ====
// Purpose: One capture/compare module of a counter array with its counter.
// Assumes: Single AHB-Lite master, whole-word single transfers.
// Notes:   Modes: capture, software timer, high-speed output,
//          frequency output and 8 to 11-bit pulse width modulation.
// How it works
// - Qualifying pin edge copies counter into compare.
// - Rise and fall enables pick capture edge.
// - Capture sets event flag; irq only if enabled.
// - Event flag cleared only by software write.
// - Pin level stays readable after any capture.
// - Software timer sets flag on 16-bit match.
// - Low byte write clears, high sets comparator.
// - High-speed output toggles pin on match.
// - Comparator off freezes high-speed output pin.
// - Frequency mode toggles, adds high to low.
// - High byte zero means half-period 256.
// - Frequency mode match flag on 16-bit equality.
// - Each module picks its own PWM cycle length.
// - 8-bit PWM: set on match, clear on overflow.
// - 8-bit PWM reloads low from high byte.
// - Comparator off gives constant low PWM.
// - PWM match with match enable sets flag.
// - Overflow flag every 2^N counter clocks.
// - Reload view routes compare bytes to reload.
// - N-bit PWM: match high, overflow low, reload.
// - Cycle select 00..11 means 8..11 bits.
`timescale 1ns/1ps
`default_nettype none
`include "cc_module_map.vh"

module cc_module #(
	parameter [15:0] TICK_DIV = `TICK_DIV_RESET
) (
	// Clock and reset
	input  wire        clk,
	input  wire        rst_b,
	// AHB-Lite slave
	input  wire        hsel,
	input  wire [31:0] haddr,
	input  wire [1:0]  htrans,
	input  wire        hwrite,
	input  wire [2:0]  hsize,
	input  wire [31:0] hwdata,
	input  wire        hready,
	output reg  [31:0] hrdata,
	output reg         hreadyout,
	output reg         hresp,
	// Module pin
	input  wire        module_io_pin_in,
	output reg         module_io_pin_out,
	output reg         module_io_pin_oe,
	// Event request towards the interrupt tree
	output reg         module_event_irq
);
	// ************************************************************
	// Reset release
	// ************************************************************
	reg rst_m;
	reg rst_sync_b;
	always @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			rst_m      <= 1'b0;
			rst_sync_b <= 1'b0;
		end else begin
			rst_m      <= 1'b1;
			rst_sync_b <= rst_m;
		end
	end

	// ************************************************************
	// Registers and state
	// ************************************************************
	reg  [7:0]  module_mode_register;
	reg  [7:0]  pulse_config_register;
	reg  [15:0] module_compare_value;
	reg  [10:0] reload_value;
	reg  [15:0] counter;
	reg  [15:0] tick_cnt;
	reg         module_event_flag;
	reg         partial_overflow_flag;
	reg         pin_prev;
	wire        pin_level;

	wire comparator_on    = module_mode_register[`MODE_COMP_ON];
	wire match_flag_en    = module_mode_register[`MODE_MATCH];
	wire toggle_en        = module_mode_register[`MODE_TOGGLE];
	wire pulse_mod_en     = module_mode_register[`MODE_PWM];
	wire rise_capture_en  = module_mode_register[`MODE_RISE];
	wire fall_capture_en  = module_mode_register[`MODE_FALL];
	wire irq_en           = module_mode_register[`MODE_IRQ_EN];
	wire [1:0] cycle_length_select =
		pulse_config_register[`CFG_CYCLE_LENGTH_SELECT_HI:`CFG_CYCLE_LENGTH_SELECT_LO];
	wire reload_view_select = pulse_config_register[`CFG_RELOAD_VIEW];

	pin_sync3 u_sync (
		.clk        (clk),
		.rst_sync_b (rst_sync_b),
		.pin_async  (module_io_pin_in),
		.pin_level  (pin_level)
	);

	// ************************************************************
	// Counter timebase
	// ************************************************************
	// Timebase selection lives outside this block; a fixed divider
	// stands in for it so the counter advances on a one-cycle enable.
	wire tick = (tick_cnt == TICK_DIV - 16'h0001);
	always @(posedge clk or negedge rst_sync_b) begin
		if (!rst_sync_b) begin
			tick_cnt <= 16'h0000;
			counter  <= 16'h0000;
		end else if (tick) begin
			tick_cnt <= 16'h0000;
			counter  <= counter + 16'h0001;
		end else begin
			tick_cnt <= tick_cnt + 16'h0001;
		end
	end

	// ************************************************************
	// Mode decode and compare logic
	// ************************************************************
	wire capture_mode = !comparator_on && !pulse_mod_en && !toggle_en &&
		!match_flag_en && (rise_capture_en || fall_capture_en);
	wire timer_mode   = comparator_on && match_flag_en && !toggle_en &&
		!pulse_mod_en;
	wire hso_mode     = toggle_en && match_flag_en && !pulse_mod_en;
	wire freq_mode    = toggle_en && pulse_mod_en;
	wire pwm_mode     = pulse_mod_en && !toggle_en;

	reg [10:0] n_mask;
	reg [11:0] ovf_bit;
	always @* begin
		case (cycle_length_select)
		2'b00: begin
			n_mask  = 11'h0FF;
			ovf_bit = 12'h100;
		end
		2'b01: begin
			n_mask  = 11'h1FF;
			ovf_bit = 12'h200;
		end
		2'b10: begin
			n_mask  = 11'h3FF;
			ovf_bit = 12'h400;
		end
		default: begin
			n_mask  = 11'h7FF;
			ovf_bit = 12'h800;
		end
		endcase
	end

	wire [11:0] cnt_n      = {1'b0, counter[10:0] & n_mask};
	wire [11:0] cnt_n_next = cnt_n + 12'h001;
	wire pwm_ovf  = tick && ((cnt_n_next & {1'b0, n_mask}) == 12'h000) &&
		((cnt_n_next & ovf_bit) != 12'h000);
	wire full_eq  = tick && (counter == module_compare_value);
	wire low_eq   = tick && (counter[7:0] == module_compare_value[7:0]);
	wire pwm_eq   = tick && ((counter[10:0] & n_mask) ==
		(module_compare_value[10:0] & n_mask));

	wire rise_edge  = pin_level && !pin_prev;
	wire fall_edge  = !pin_level && pin_prev;
	wire capture_ev = capture_mode &&
		((rise_capture_en && rise_edge) || (fall_capture_en && fall_edge));

	reg event_set;
	always @* begin
		event_set = 1'b0;
		if (capture_ev)
			event_set = 1'b1;
		else if (timer_mode && full_eq)
			event_set = 1'b1;
		else if (hso_mode && comparator_on && full_eq)
			event_set = 1'b1;
		else if (freq_mode && comparator_on && match_flag_en && full_eq)
			event_set = 1'b1;
		else if (pwm_mode && comparator_on && match_flag_en && pwm_eq)
			event_set = 1'b1;
	end

	// ************************************************************
	// AHB-Lite slave
	// ************************************************************
	reg        ph_write;
	reg        ph_valid;
	reg [7:0]  ph_addr;
	wire       take = hsel && htrans[1] && hready;

	always @(posedge clk or negedge rst_sync_b) begin
		if (!rst_sync_b) begin
			ph_write <= 1'b0;
			ph_valid <= 1'b0;
			ph_addr  <= 8'h00;
		end else begin
			ph_valid <= take;
			ph_write <= take && hwrite;
			if (take)
				ph_addr <= haddr[7:0];
		end
	end

	wire wr         = ph_valid && ph_write;
	wire wr_low     = wr && (ph_addr == `OFS_CMP_LOW);
	wire wr_high    = wr && (ph_addr == `OFS_CMP_HIGH);
	wire wr_status  = wr && (ph_addr == `OFS_STATUS);

	// ************************************************************
	// Register updates and pin behaviour
	// ************************************************************
	reg [15:0] next_cmp;
	always @* begin
		next_cmp = module_compare_value;
		if (capture_ev)
			next_cmp = counter;
		else if (freq_mode && comparator_on && low_eq)
			next_cmp[7:0] = module_compare_value[7:0] +
				module_compare_value[15:8];
		else if (pwm_mode && pwm_ovf && cycle_length_select == 2'b00)
			next_cmp[7:0] = module_compare_value[15:8];
		else if (pwm_mode && pwm_ovf)
			next_cmp = {5'h00, reload_value};
		if (wr_low && !reload_view_select)
			next_cmp[7:0] = hwdata[7:0];
		if (wr_high && !reload_view_select)
			next_cmp[15:8] = hwdata[7:0];
	end

	always @(posedge clk or negedge rst_sync_b) begin
		if (!rst_sync_b) begin
			module_mode_register  <= `MODE_RESET;
			pulse_config_register <= `CFG_RESET;
			module_compare_value  <= 16'h0000;
			reload_value          <= 11'h000;
			module_event_flag     <= 1'b0;
			partial_overflow_flag <= 1'b0;
			pin_prev              <= 1'b0;
		end else begin
			pin_prev             <= pin_level;
			module_compare_value <= next_cmp;
			if (wr && ph_addr == `OFS_MODE)
				module_mode_register <= hwdata[7:0];
			if (wr && ph_addr == `OFS_PULSE_CFG)
				pulse_config_register <= hwdata[7:0];
			if (wr_low)
				module_mode_register[`MODE_COMP_ON] <= 1'b0;
			if (wr_high)
				module_mode_register[`MODE_COMP_ON] <= 1'b1;
			if (wr_low && reload_view_select)
				reload_value[7:0] <= hwdata[7:0];
			if (wr_high && reload_view_select)
				reload_value[10:8] <= hwdata[2:0];
			// Set wins over a clear in the same cycle.
			if (event_set)
				module_event_flag <= 1'b1;
			else if (wr_status && hwdata[`STAT_EVENT])
				module_event_flag <= 1'b0;
			if (pwm_mode && pwm_ovf)
				partial_overflow_flag <= 1'b1;
			else if (wr_status && hwdata[`STAT_OVF])
				partial_overflow_flag <= 1'b0;
		end
	end

	// Pin driver. Capture and software timer leave the pin undriven.
	always @(posedge clk or negedge rst_sync_b) begin
		if (!rst_sync_b) begin
			module_io_pin_out <= 1'b0;
			module_io_pin_oe  <= 1'b0;
		end else begin
			module_io_pin_oe <= hso_mode || freq_mode || pwm_mode;
			if (hso_mode) begin
				if (comparator_on && full_eq)
					module_io_pin_out <= !module_io_pin_out;
			end else if (freq_mode) begin
				if (comparator_on && low_eq)
					module_io_pin_out <= !module_io_pin_out;
			end else if (pwm_mode) begin
				if (!comparator_on)
					module_io_pin_out <= 1'b0;
				else if (pwm_ovf)
					module_io_pin_out <= 1'b0;
				else if (pwm_eq)
					module_io_pin_out <= 1'b1;
			end
		end
	end

	// ************************************************************
	// Read data and responses
	// ************************************************************
	reg [31:0] next_rdata;
	always @* begin
		next_rdata = 32'h0000_0000;
		case (haddr[7:0])
		`OFS_MODE:      next_rdata[7:0] = module_mode_register;
		`OFS_CMP_LOW:   next_rdata[7:0] = reload_view_select ?
			reload_value[7:0] : module_compare_value[7:0];
		`OFS_CMP_HIGH:  next_rdata[7:0] = reload_view_select ?
			{5'h00, reload_value[10:8]} : module_compare_value[15:8];
		`OFS_PULSE_CFG: next_rdata[7:0] = pulse_config_register;
		`OFS_STATUS:    next_rdata[1:0] =
			{partial_overflow_flag, module_event_flag};
		`OFS_COUNTER:   next_rdata[15:0] = counter;
		`OFS_PIN:       next_rdata[0] = pin_level;
		default:        next_rdata = 32'h0000_0000;
		endcase
	end

	always @(posedge clk or negedge rst_sync_b) begin
		if (!rst_sync_b) begin
			hrdata           <= 32'h0000_0000;
			hreadyout        <= 1'b1;
			hresp            <= 1'b0;
			module_event_irq <= 1'b0;
		end else begin
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
			if (take && !hwrite)
				hrdata <= next_rdata;
			module_event_irq <= module_event_flag && irq_en;
		end
	end
endmodule // cc_module

`default_nettype wire

// ==== common/cc_module_map.vh ====
// Purpose: Offsets, field positions, reset values and timing counts.
// Assumes: Byte addresses on a 32-bit AHB-Lite register bus.
// Notes:   Definitions only.
`ifndef CC_MODULE_MAP_VH
`define CC_MODULE_MAP_VH

// Register byte addresses.
`define OFS_MODE        8'h00
`define OFS_CMP_LOW     8'h04
`define OFS_CMP_HIGH    8'h08
`define OFS_PULSE_CFG   8'h0C
`define OFS_STATUS      8'h10
`define OFS_COUNTER     8'h14
`define OFS_PIN         8'h18

// Mode register fields.
`define MODE_IRQ_EN     0
`define MODE_TOGGLE     1
`define MODE_MATCH      2
`define MODE_FALL       3
`define MODE_RISE       4
`define MODE_COMP_ON    5
`define MODE_PWM        6
`define MODE_RESET      8'h00

// Pulse configuration register fields.
`define CFG_CYCLE_LENGTH_SELECT_LO    0
`define CFG_CYCLE_LENGTH_SELECT_HI    1
`define CFG_RELOAD_VIEW 7
`define CFG_RESET       8'h00

// Status register fields (write one to clear).
`define STAT_EVENT      0
`define STAT_OVF        1

// Counter prescaler: one counter tick every this many system clocks.
`define TICK_DIV_RESET  16'h0001

`endif

// ==== verilog/pin_sync3.v ====
// Purpose: Three-stage synchroniser for the module pin input.
// Assumes: Pin level may change at any time relative to clk.
// Notes:   A change counts once the second and third stages agree.
`timescale 1ns/1ps
`default_nettype none

module pin_sync3 (
	// Clock and reset
	input  wire clk,
	input  wire rst_sync_b,
	// Pin in, clean level out
	input  wire pin_async,
	output reg  pin_level
);
	reg s1;
	reg s2;
	reg s3;

	always @(posedge clk or negedge rst_sync_b) begin
		if (!rst_sync_b) begin
			s1        <= 1'b0;
			s2        <= 1'b0;
			s3        <= 1'b0;
			pin_level <= 1'b0;
		end else begin
			s1 <= pin_async;
			s2 <= s1;
			s3 <= s2;
			if (s2 == s3)
				pin_level <= s3;
		end
	end
endmodule // pin_sync3

`default_nettype wire

// ==== sim/cc_module_asserts.sv ====
// Purpose: Port checks for the capture/compare module.
// Assumes: Writes land at the end of the data phase.
// Notes:   Mode bits are shadowed from bus writes.
`timescale 1ns/1ps
`default_nettype none
`include "cc_module_map.vh"

module cc_module_asserts #(
	parameter [15:0] TICK_DIV = 16'h0001
) (
	// Clock and reset
	input wire logic        clk,
	input wire logic        rst_b,
	// Bus
	input wire logic        hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0]  htrans,
	input wire logic        hwrite,
	input wire logic [31:0] hwdata,
	input wire logic        hready,
	input wire logic [31:0] hrdata,
	input wire logic        hresp,
	// Pin and event
	input wire logic        module_io_pin_out,
	input wire logic        module_io_pin_oe,
	input wire logic        module_event_irq
);
	logic        wr, rd, last;
	logic [7:0]  a, md;
	logic [1:0]  cl;
	logic [12:0] quiet;
	logic [15:0] per;
	// Mode checks wait for quiet, so a stale compare value has cleared.
	always @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			{wr, rd, last, a, md, cl, quiet, per} <= '0;
		end else begin
			wr <= hsel & htrans[1] & hready & hwrite;
			rd <= hsel & htrans[1] & hready & ~hwrite;
			a <= haddr[7:0];
			last <= module_io_pin_out;
			per <= (module_io_pin_out & ~last) ? 16'h0000 : per + 16'h0001;
			if (wr)
				quiet <= 13'h0000;
			else if (quiet != 13'h1FFF)
				quiet <= quiet + 13'h0001;
			if (wr && a == `OFS_MODE)
				md <= hwdata[7:0];
			if (wr && a == `OFS_CMP_LOW)
				md[5] <= 1'b0;
			if (wr && a == `OFS_CMP_HIGH)
				md[5] <= 1'b1;
			if (wr && a == `OFS_PULSE_CFG)
				cl <= hwdata[1:0];
		end
	end

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_b);

	okay_resp_a: assert property (!hresp)
		else $error("response not OKAY");
	rdata_hold_a: assert property ($changed(hrdata) |-> rd)
		else $error("read data moved without a read");
	irq_gate_a: assert property (
		!md[0] && quiet > 13'd3 |-> !module_event_irq)
		else $error("request while disabled");
	flag_sticky_a: assert property (
		$fell(module_event_irq) |-> quiet < 13'd4)
		else $error("flag cleared without a write");
	cap_undriven_a: assert property (
		!md[6] && !md[1] && quiet > 13'd3 |-> !module_io_pin_oe)
		else $error("pin driven in capture mode");
	hso_freeze_a: assert property (
		md[1] && md[2] && !md[5] && !md[6] && quiet > 13'd3
		|-> $stable(module_io_pin_out))
		else $error("pin moved, comparator off");
	pwm_off_a: assert property (
		md[6] && !md[1] && !md[5] && quiet > 13'd3 |-> !module_io_pin_out)
		else $error("pwm high, comparator off");
	pwm_period_a: assert property (
		quiet == 13'h1FFF && md[6] && !md[1] && md[5]
		&& module_io_pin_out && !last
		|-> per == (16'h0100 << cl) * TICK_DIV - 16'h0001)
		else $error("pwm period wrong");
endmodule // cc_module_asserts

bind cc_module cc_module_asserts #(.TICK_DIV(TICK_DIV)) u_chk (
	.clk(clk), .rst_b(rst_b), .hsel(hsel), .haddr(haddr),
	.htrans(htrans), .hwrite(hwrite), .hwdata(hwdata),
	.hready(hready), .hrdata(hrdata), .hresp(hresp),
	.module_io_pin_out(module_io_pin_out),
	.module_io_pin_oe(module_io_pin_oe),
	.module_event_irq(module_event_irq)
);
`default_nettype wire

// ==== sim/pin_source.sv ====
// Purpose: Signal source and load on the module pin.
// Assumes: The bench asks for levels through lvl.
// Notes:   The design's drive wins while its enable is high.
`timescale 1ns/1ps
`default_nettype none

module pin_source (
	// Clock
	input  wire logic clk,
	// Requested level and design drive
	input  wire logic lvl,
	input  wire logic oe,
	input  wire logic drv,
	// Resolved pin
	output wire logic pin
);
	logic       src = 1'b0;
	logic [1:0] held = 2'h0;
	// A new level waits until the old one has stood three clocks.
	always @(posedge clk) begin
		if (lvl != src && held == 2'h2) begin
			src <= lvl;
			held <= 2'h0;
		end else if (held != 2'h2) begin
			held <= held + 2'h1;
		end
	end
	assign pin = oe ? drv : src;
endmodule // pin_source
`default_nettype wire

// ==== sim/cc_module_tb.sv ====
// Purpose: Self-checking bench for the capture/compare module.
// Assumes: The counter ticks every clock.
// Notes:   Each scenario task checks its own results.
`timescale 1ns/1ps
`default_nettype none
`include "cc_module_map.vh"

module cc_module_tb;
	logic        clk = 1'b0, rst_b = 1'b0, hsel = 1'b0, hwrite = 1'b0;
	logic        lvl = 1'b0;
	logic [1:0]  htrans = 2'h0;
	logic [31:0] haddr = 32'h0, hwdata = 32'h0, r;
	logic [15:0] c;
	logic [7:0]  lo;
	wire  [31:0] hrdata;
	wire         hrdy, hresp, pin, pout, poe, irq;
	int          n_mismatch = 0, tests_run = 0, t;

	initial forever #20 clk = ~clk;

	cc_module uut (
		.clk(clk), .rst_b(rst_b), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
		.hwdata(hwdata), .hready(hrdy), .hrdata(hrdata),
		.hreadyout(hrdy), .hresp(hresp), .module_io_pin_in(pin),
		.module_io_pin_out(pout), .module_io_pin_oe(poe),
		.module_event_irq(irq)
	);
	pin_source src (.clk(clk), .lvl(lvl), .oe(poe), .drv(pout), .pin(pin));

	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		tests_run++;
		if (g !== e) begin
			n_mismatch++;
			$display("[ERR] %0t got %h, expected %h", $time, g, e);
		end
	endtask

	// Read data is taken at the edge that ends the data phase.
	task automatic bus(input logic w, input logic [7:0] a,
			input logic [31:0] d);
		@(posedge clk);
		hsel <= 1'b1;
		htrans <= 2'h2;
		hwrite <= w;
		haddr <= {24'h0, a};
		do @(posedge clk); while (hrdy !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge clk); while (hrdy !== 1'b1);
		r = hrdata;
	endtask

	task automatic wait_pin(input logic v);
		for (int i = 0; i < 5000 && pin !== v; i++) begin
			@(posedge clk);
			t++;
		end
	endtask

	// Rising edge to rising edge, in clocks.
	task automatic per(input int e);
		wait_pin(1'b0);
		wait_pin(1'b1);
		t = 0;
		wait_pin(1'b0);
		wait_pin(1'b1);
		chk(t, e);
	endtask

	task automatic capture(input logic [7:0] m, input logic er, ef);
		bus(1'b1, `OFS_MODE, {24'h0, m});
		bus(1'b1, `OFS_STATUS, 32'h3);
		bus(1'b0, `OFS_COUNTER, 32'h0);
		c = r[15:0];
		lvl <= 1'b1;
		repeat (12) @(posedge clk);
		chk(irq, er);
		bus(1'b0, `OFS_STATUS, 32'h0);
		chk(r[0], er);
		bus(1'b0, `OFS_PIN, 32'h0);
		chk(r[0], 1'b1);
		bus(1'b0, `OFS_CMP_LOW, 32'h0);
		lo = r[7:0];
		bus(1'b0, `OFS_CMP_HIGH, 32'h0);
		if (er) chk({r[7:0], lo} - c < 16'd24, 1'b1);
		chk(irq, er);
		bus(1'b1, `OFS_STATUS, 32'h1);
		repeat (2) @(posedge clk);
		chk(irq, 1'b0);
		lvl <= 1'b0;
		repeat (12) @(posedge clk);
		bus(1'b0, `OFS_STATUS, 32'h0);
		chk(r[0], ef);
		$display("capture %h done", m);
	endtask

	task automatic timer(input logic [7:0] m);
		logic p;
		bus(1'b1, `OFS_MODE, {24'h0, m});
		bus(1'b1, `OFS_STATUS, 32'h3);
		bus(1'b0, `OFS_COUNTER, 32'h0);
		c = r[15:0] + 16'd40;
		bus(1'b1, `OFS_CMP_LOW, {24'h0, c[7:0]});
		bus(1'b0, `OFS_MODE, 32'h0);
		chk(r[5], 1'b0);
		bus(1'b1, `OFS_CMP_HIGH, {24'h0, c[15:8]});
		p = pin;
		bus(1'b0, `OFS_MODE, 32'h0);
		chk(r[5], 1'b1);
		repeat (60) @(posedge clk);
		bus(1'b0, `OFS_STATUS, 32'h0);
		chk(r[0], 1'b1);
		chk(pin, p ^ m[1]);
		bus(1'b1, `OFS_CMP_LOW, 32'h0);
		repeat (8) @(posedge clk);
		$display("timer %h done", m);
	endtask

	task automatic freq(input logic [7:0] h, input int e);
		bus(1'b1, `OFS_MODE, 32'h62);
		bus(1'b1, `OFS_CMP_LOW, 32'h0);
		bus(1'b1, `OFS_CMP_HIGH, {24'h0, h});
		per(e);
		$display("frequency %h done", h);
	endtask

	task automatic pwm(input logic [1:0] n);
		bus(1'b1, `OFS_STATUS, 32'h3);
		bus(1'b1, `OFS_PULSE_CFG, {24'h0, |n, 5'h0, n});
		bus(1'b1, `OFS_CMP_LOW, 32'h7F);
		bus(1'b1, `OFS_CMP_HIGH, (n == 2'h0) ? 32'h80 : 32'h01);
		bus(1'b1, `OFS_MODE, 32'h64);
		per(256 << n);
		bus(1'b0, `OFS_STATUS, 32'h0);
		chk(r[1:0], 2'h3);
		bus(1'b0, `OFS_CMP_HIGH, 32'h0);
		chk(r[7:0], (n == 2'h0) ? 8'h80 : 8'h01);
		if (n == 2'h0) repeat (8300) @(posedge clk);
		$display("pwm length %0d done", n);
	endtask

	task automatic wrap_up;
		$display("%0d compares, %0d mismatches", tests_run, n_mismatch);
		if (n_mismatch == 0 && tests_run > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	initial begin
		repeat (16) @(posedge clk);
		rst_b <= 1'b1;
		repeat (3) @(posedge clk);
		bus(1'b0, `OFS_MODE, 32'h0);
		chk(r, {24'h0, `MODE_RESET});
		bus(1'b0, 8'h1C, 32'h0);
		chk(r, 32'h0);
		capture(8'h11, 1'b1, 1'b0);
		capture(8'h09, 1'b0, 1'b1);
		capture(8'h19, 1'b1, 1'b1);
		timer(8'h24);
		timer(8'h26);
		freq(8'h0A, 20);
		freq(8'h00, 512);
		for (int i = 0; i < 4; i++) pwm(i[1:0]);
		bus(1'b1, `OFS_PULSE_CFG, 32'h0);
		bus(1'b1, `OFS_CMP_LOW, 32'h0);
		repeat (8) @(posedge clk);
		chk(pin, 1'b0);
		wrap_up();
	end

	initial begin
		#3000000;
		n_mismatch++;
		$display("[ERR] %0t watchdog expired", $time);
		wrap_up();
	end
endmodule // cc_module_tb
`default_nettype wire
